// file: design/predriver_mode_fault_control.sv
// mode sequencing, phase error detection and gate-supply undervoltage
// handling for a three-phase gate pre-driver
// assumes all pins are synchronous to clk_i and the serial core delivers
// one command byte per frame as a pulse on command_valid_i
`timescale 1ns/1ps

// Operation
// - high-side on, node low: high-side error
// - low-side on, node high: low-side error
// - phase error flag ORs all phase errors
// - unmasked flag holds interrupt until cleared
// - undervoltage: strong off, then weak hold-off
// - undervoltage acts only after filter time
// - recovery: low side follows, high side inhibited
// - high side floats until low side off
// - reset or disable level: weak hold-off
// - reset low: sleep, clear, clamp outputs
// - enable low: standby, drivers actively off
// - serial out driven only while selected
// - both enables high: init, toggles complete
// - enable mode: gates follow input commands
// - high side waits for low-side pulse
// - faults enter protection, need reinitialization
// - open inputs default to drivers off
// - deadtime starts at command change
// - clear command 0111 clears flagged latches
module predriver_mode_fault_control
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic enable_input_first_i,
  input wire logic enable_input_second_i,
  input wire logic [2:0] low_side_command_in_i,
  input wire logic [2:0] high_side_command_in_n_i,
  input wire logic [2:0] phase_node_sense_i,
  input wire logic gate_drive_supply_low_i,
  input wire logic gate_supply_disable_level_i,
  input wire logic desat_detect_i,
  input wire logic protect_enable_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  input wire logic command_valid_i,
  input wire logic [7:0] command_byte_i,
  output logic [2:0] hs_gate_on_o,
  output logic [2:0] hs_gate_off_o,
  output logic [2:0] ls_gate_on_o,
  output logic [2:0] ls_gate_off_o,
  output logic hold_off_o,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic interrupt_o,
  output logic phase_error_o,
  output logic [3:0] status_upper_o,
  output logic [3:0] interrupt_mask_upper_o,
  output predriver_pkg::mode_t mode_o
);
  import predriver_pkg::*;

  mode_t mode_reg;
  mode_t mode_next;
  logic [UV_CNT_W-1:0] uv_cnt_reg;
  logic [STRONG_CNT_W-1:0] strong_cnt_reg;
  logic [PHASE_TMR_W-1:0] phase_tmr_reg [PHASE_COUNT];
  logic [2:0] hs_err_reg;
  logic [2:0] ls_err_reg;
  logic [2:0] req_hs_prev_reg;
  logic [2:0] req_ls_prev_reg;
  logic [2:0] ls_cmd_prev_reg;
  logic [2:0] hs_cmd_prev_reg;
  logic [2:0] init_ls_done_reg;
  logic [2:0] init_hs_done_reg;
  logic [2:0] ls_pulsed_reg;
  logic [2:0] hs_float_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic serial_out_reg;
  logic sleep;
  logic both_enabled;
  logic supply_disabled;
  logic uv_filtered;
  logic uv_strong;
  logic uv_weak;
  logic active;
  logic drive_allowed;
  logic phase_err_any;
  logic fault_cause;
  logic [2:0] hs_cmd;
  logic [2:0] req_hs;
  logic [2:0] req_ls;
  logic [2:0] req_change;
  logic [2:0] dt_done;
  logic [2:0] sample_now;
  logic [2:0] ls_fall;
  logic [2:0] hs_fall;
  logic [2:0] hs_on;
  logic [2:0] ls_on;
  logic clear_cmd;
  logic mask_cmd;
  logic [3:0] flag_set;
  // open defaults
  // high-side command and chip select are active low, so a floating
  // pin pulled high leaves the high-side gates off and the serial output undriven
  assign hs_cmd = ~high_side_command_in_n_i;
  assign sleep = ~reset_pin_n_i;
  assign both_enabled = enable_input_first_i & enable_input_second_i;
  assign supply_disabled = gate_supply_disable_level_i;
  assign active = ~sleep & ~supply_disabled;
  assign uv_filtered = (uv_cnt_reg == UV_FILTER_LAST);
  assign uv_strong = uv_filtered & (strong_cnt_reg < STRONG_OFF_LAST);
  assign uv_weak = uv_filtered & ~uv_strong;
  // both sides requested at once means neither, avoiding shoot-through
  assign req_hs = hs_cmd & ~low_side_command_in_i;
  assign req_ls = low_side_command_in_i & ~hs_cmd;
  assign req_change = (req_hs ^ req_hs_prev_reg) | (req_ls ^ req_ls_prev_reg);
  assign ls_fall = ls_cmd_prev_reg & ~low_side_command_in_i;
  assign hs_fall = hs_cmd_prev_reg & ~hs_cmd;
  always_comb
  begin
    for (int p = 0; p < PHASE_COUNT; p++)
    begin
      dt_done[p] = (phase_tmr_reg[p] >= DEADTIME_LAST) & ~req_change[p];
      sample_now[p] = (phase_tmr_reg[p] == SAMPLE_AT) & ~req_change[p];
    end
  end
  assign drive_allowed = active & ~uv_filtered &
                         ((mode_reg == MODE_INIT) ||
                          (mode_reg == MODE_ENABLE));
  assign ls_on = {3{drive_allowed}} & req_ls & dt_done;
  assign hs_on = {3{drive_allowed & (mode_reg == MODE_ENABLE)}} &
                 req_hs & dt_done & ls_pulsed_reg & ~hs_float_reg;
  assign phase_err_any = |(hs_err_reg | ls_err_reg);
  // protection causes
  // desat and phase errors only shut down while protection is enabled
  assign fault_cause = uv_filtered |
                       (protect_enable_i & (desat_detect_i | phase_err_any));
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      uv_cnt_reg <= '0;
    else if (!gate_drive_supply_low_i || sleep)
      uv_cnt_reg <= '0;
    else if (!uv_filtered)
      uv_cnt_reg <= uv_cnt_reg + UV_CNT_W'(1);
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      strong_cnt_reg <= '0;
    else if (!uv_filtered)
      strong_cnt_reg <= '0;
    else if (uv_strong)
      strong_cnt_reg <= strong_cnt_reg + STRONG_CNT_W'(1);
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int p = 0; p < PHASE_COUNT; p++)
        phase_tmr_reg[p] <= '0;
      req_hs_prev_reg <= '0;
      req_ls_prev_reg <= '0;
      ls_cmd_prev_reg <= '0;
      hs_cmd_prev_reg <= '0;
    end
    else
    begin
      req_hs_prev_reg <= req_hs;
      req_ls_prev_reg <= req_ls;
      ls_cmd_prev_reg <= low_side_command_in_i;
      hs_cmd_prev_reg <= hs_cmd;
      for (int p = 0; p < PHASE_COUNT; p++)
      begin
        if (req_change[p])
          phase_tmr_reg[p] <= '0;
        else if (phase_tmr_reg[p] < SETTLE_LAST)
          phase_tmr_reg[p] <= phase_tmr_reg[p] + PHASE_TMR_W'(1);
      end
    end
  end
  // an error stands until the next sample of its phase or a new command,
  // so a fixed fault keeps re-setting the latch and holds the interrupt
  always_ff @(posedge clk_i)
  begin
    if (reset_i || sleep)
    begin
      hs_err_reg <= '0;
      ls_err_reg <= '0;
    end
    else
    begin
      for (int p = 0; p < PHASE_COUNT; p++)
      begin
        if (req_change[p])
        begin
          hs_err_reg[p] <= 1'b0;
          ls_err_reg[p] <= 1'b0;
        end
        else if (sample_now[p])
        begin
          hs_err_reg[p] <= hs_on[p] & ~phase_node_sense_i[p];
          ls_err_reg[p] <= ls_on[p] & phase_node_sense_i[p];
        end
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || mode_reg != MODE_INIT)
    begin
      init_ls_done_reg <= '0;
      init_hs_done_reg <= '0;
    end
    else
    begin
      init_ls_done_reg <= init_ls_done_reg | ls_fall;
      if (&init_ls_done_reg)
        init_hs_done_reg <= init_hs_done_reg | hs_fall;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || mode_reg != MODE_ENABLE)
      ls_pulsed_reg <= '0;
    else
      ls_pulsed_reg <= ls_pulsed_reg | ls_fall;
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || sleep)
      hs_float_reg <= '0;
    else if (uv_filtered)
      hs_float_reg <= '1;
    else
      hs_float_reg <= hs_float_reg & low_side_command_in_i;
  end
  always_comb
  begin
    mode_next = mode_reg;
    if (sleep)
      mode_next = MODE_SLEEP;
    else if (!both_enabled)
      mode_next = MODE_STANDBY;
    else
    begin
      unique case (mode_reg)
        MODE_SLEEP:
          mode_next = MODE_STANDBY;
        MODE_STANDBY:
          mode_next = MODE_INIT;
        MODE_INIT:
        begin
          if (fault_cause)
            mode_next = MODE_FAULT;
          else if (&init_hs_done_reg)
            mode_next = MODE_ENABLE;
        end
        MODE_ENABLE:
        begin
          if (fault_cause)
            mode_next = MODE_FAULT;
        end
        MODE_FAULT:
        begin
          if (!fault_cause)
            mode_next = MODE_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      mode_reg <= MODE_SLEEP;
    else
      mode_reg <= mode_next;
  end

  assign clear_cmd = command_valid_i & ~sleep &
                     (command_byte_i[7:4] == CMD_CLEAR_UPPER);
  assign mask_cmd = command_valid_i & ~sleep &
                    (command_byte_i[7:4] == CMD_MASK_UPPER);

  always_comb
  begin
    flag_set = 4'h0;
    flag_set[FLAG_PHASE_ERR] = phase_err_any;
    flag_set[FLAG_GATE_UV] = uv_filtered;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || sleep)
      status_reg <= STATUS_UPPER_RESET;
    // clear flagged bits
    // a new event in the clearing cycle still sets its bit
    else if (clear_cmd)
      status_reg <= (status_reg & ~command_byte_i[3:0]) | flag_set;
    else
      status_reg <= status_reg | flag_set;
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || sleep)
      mask_reg <= MASK_UPPER_RESET;
    else if (mask_cmd)
      mask_reg <= command_byte_i[3:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      serial_out_reg <= 1'b0;
    else
      serial_out_reg <= serial_data_i;
  end
  assign serial_out_oe_o = ~sleep & ~chip_select_n_i;
  assign serial_out_o = serial_out_reg;
  assign interrupt_o = ~sleep & (|(status_reg & mask_reg));
  assign phase_error_o = ~sleep & phase_err_any;
  assign status_upper_o = status_reg;
  assign interrupt_mask_upper_o = mask_reg;
  assign mode_o = mode_reg;
  assign hold_off_o = sleep | supply_disabled | uv_weak;
  assign hs_gate_on_o = hs_on;
  assign ls_gate_on_o = ls_on;
  assign hs_gate_off_o = {3{active & ~uv_weak}} & ~hs_on &
                         (~hs_float_reg | {3{uv_strong}});
  assign ls_gate_off_o = {3{active & ~uv_weak}} & ~ls_on;

endmodule

// file: shared/predriver_pkg.sv
// constants, mode encoding and timing for the gate pre-driver control logic
// assumes a single 250 MHz timebase drives every counter of the block
package predriver_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int PHASE_COUNT = 3;

  // undervoltage filter, least time: round up
  localparam int UV_FILTER_NS = 700;
  localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // strong turn-off after undervoltage, then weak hold-off
  localparam int STRONG_OFF_NS = 8000;
  localparam int STRONG_OFF_CYC = STRONG_OFF_NS / CLK_PERIOD_NS;

  // deadtime and blanking intervals, least times: round up
  localparam int DEADTIME_NS = 100;
  localparam int BLANK_NS = 200;
  localparam int DEADTIME_CYC = (DEADTIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = DEADTIME_CYC + BLANK_CYC;

  localparam int UV_CNT_W = 8;
  localparam int STRONG_CNT_W = 11;
  localparam int PHASE_TMR_W = 8;

  localparam logic [UV_CNT_W-1:0] UV_FILTER_LAST = UV_CNT_W'(UV_FILTER_CYC);
  localparam logic [STRONG_CNT_W-1:0] STRONG_OFF_LAST =
    STRONG_CNT_W'(STRONG_OFF_CYC);
  localparam logic [PHASE_TMR_W-1:0] DEADTIME_LAST =
    PHASE_TMR_W'(DEADTIME_CYC);
  localparam logic [PHASE_TMR_W-1:0] SETTLE_LAST = PHASE_TMR_W'(SETTLE_CYC);
  localparam logic [PHASE_TMR_W-1:0] SAMPLE_AT = PHASE_TMR_W'(SETTLE_CYC - 1);

  // command byte: upper nibble opcode, lower nibble per-flag bits
  localparam logic [3:0] CMD_MASK_UPPER = 4'h3;
  localparam logic [3:0] CMD_CLEAR_UPPER = 4'h7;
  localparam logic [3:0] MASK_UPPER_RESET = 4'hF;
  localparam logic [3:0] STATUS_UPPER_RESET = 4'h0;

  // positions in the upper fault latch group
  localparam int FLAG_PHASE_ERR = 0;
  localparam int FLAG_GATE_UV = 1;

  typedef enum logic [4:0]
  {
    MODE_SLEEP = 5'h01,
    MODE_STANDBY = 5'h02,
    MODE_INIT = 5'h04,
    MODE_ENABLE = 5'h08,
    MODE_FAULT = 5'h10
  } mode_t;

endpackage

// file: tb/predriver_mode_fault_control_assertions.sv
// port checker for the pre-driver mode and fault control
// assumes one clock domain, bound to the top module from the bench
`timescale 1ns/1ps
module predriver_mode_fault_control_assertions
  import predriver_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic enable_input_first_i,
  input wire logic gate_drive_supply_low_i,
  input wire logic gate_supply_disable_level_i,
  input wire logic chip_select_n_i,
  input wire logic command_valid_i,
  input wire logic [2:0] hs_gate_on_o,
  input wire logic hold_off_o,
  input wire logic serial_out_oe_o,
  input wire logic interrupt_o,
  input wire logic phase_error_o,
  input wire logic [3:0] status_upper_o,
  input wire logic [3:0] interrupt_mask_upper_o,
  input wire predriver_pkg::mode_t mode_o
);
  // consecutive cycles of raw undervoltage, saturating
  logic [7:0] uv_run_reg;
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !gate_drive_supply_low_i)
    begin
      uv_run_reg <= 8'h00;
    end
    else if (uv_run_reg != 8'hFF)
    begin
      uv_run_reg <= uv_run_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  property p_sleep;
    !reset_pin_n_i
      |-> !interrupt_o && !serial_out_oe_o && hs_gate_on_o == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep clamp broken");
  property p_hold;
    !reset_pin_n_i || gate_supply_disable_level_i |-> hold_off_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold off missing");
  property p_oe;
    chip_select_n_i |-> !serial_out_oe_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("serial out driven unselected");
  property p_hs_mode;
    hs_gate_on_o != 3'h0 |-> mode_o == MODE_ENABLE;
  endproperty
  a_hs_mode: assert property (p_hs_mode)
    else $error("high side on outside enable");
  property p_int;
    // without a command the interrupt can only fall by going to sleep
    interrupt_o && reset_pin_n_i && !command_valid_i
      |=> interrupt_o || !reset_pin_n_i;
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt level wrong");
  property p_latch;
    phase_error_o && reset_pin_n_i |=> status_upper_o[0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("phase error not latched");
  property p_uv;
    $rose(status_upper_o[1]) |-> uv_run_reg >= 8'(UV_FILTER_CYC - 1);
  endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage acted before filter");
  property p_standby;
    mode_o != MODE_SLEEP && reset_pin_n_i && !enable_input_first_i
      |=> mode_o == MODE_STANDBY;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not entered");
  c_fault: cover property (mode_o == MODE_ENABLE ##1 mode_o == MODE_FAULT);
  c_irq: cover property ($rose(interrupt_o));
  c_init: cover property (mode_o == MODE_INIT ##1 mode_o == MODE_ENABLE);
endmodule

// file: tb/host_model.sv
// host controller model: reset pin, enables, gate commands, command bytes
// assumes the caller enters each task just after a rising clock edge
`timescale 1ns/1ps
module host_model
(
  input wire logic clk_i,
  output logic reset_pin_n_o,
  output logic en_first_o,
  output logic en_second_o,
  output logic [2:0] ls_cmd_o,
  output logic [2:0] hs_cmd_n_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o
);
  initial
  begin
    reset_pin_n_o = 1'b0;
    en_first_o = 1'b0;
    en_second_o = 1'b0;
    ls_cmd_o = 3'h0;
    hs_cmd_n_o = 3'h7;
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic set_pins(input logic rst_n, input logic en);
    reset_pin_n_o <= rst_n;
    en_first_o <= en;
    en_second_o <= en;
  endtask
  task automatic set_gates(input logic [2:0] ls, input logic [2:0] hs_n);
    ls_cmd_o <= ls;
    hs_cmd_n_o <= hs_n;
  endtask
  // one byte per frame, pulse only
  task automatic send_cmd(input logic [7:0] b);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= b;
    tick(1);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~b;
    tick(1);
  endtask
  // low sides toggled, then high sides
  task automatic init_run();
    set_pins(1'b1, 1'b1);
    tick(3);
    ls_cmd_o <= 3'h7;
    tick(30);
    ls_cmd_o <= 3'h0;
    tick(3);
    hs_cmd_n_o <= 3'h0;
    tick(3);
    hs_cmd_n_o <= 3'h7;
    tick(3);
  endtask
endmodule

// file: tb/predriver_mode_fault_control_tb.sv
// bench for the pre-driver mode and fault control block
// assumes host_model drives host pins; the bench plays the power stage
`timescale 1ns/1ps
module predriver_mode_fault_control_tb;
  import predriver_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reset_pin_n_i, enable_input_first_i, enable_input_second_i;
  logic [2:0] low_side_command_in_i, high_side_command_in_n_i;
  logic [2:0] phase_node_sense_i = 3'h0;
  logic gate_drive_supply_low_i = 1'b0;
  logic gate_supply_disable_level_i = 1'b0;
  logic desat_detect_i = 1'b0;
  logic protect_enable_i = 1'b0;
  logic chip_select_n_i = 1'b1;
  logic serial_data_i = 1'b0;
  logic command_valid_i;
  logic [7:0] command_byte_i;
  logic [2:0] hs_gate_on_o, hs_gate_off_o, ls_gate_on_o, ls_gate_off_o;
  logic hold_off_o, serial_out_o, serial_out_oe_o, interrupt_o, phase_error_o;
  logic [3:0] status_upper_o, interrupt_mask_upper_o;
  mode_t mode_o;
  int fail_count = 0;
  int compares = 0;
  always #2 clk_i = ~clk_i;
  predriver_mode_fault_control u_predriver_mode_fault_control
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .reset_pin_n_i(reset_pin_n_i),
    .enable_input_first_i(enable_input_first_i),
    .enable_input_second_i(enable_input_second_i),
    .low_side_command_in_i(low_side_command_in_i),
    .high_side_command_in_n_i(high_side_command_in_n_i),
    .phase_node_sense_i(phase_node_sense_i),
    .gate_drive_supply_low_i(gate_drive_supply_low_i),
    .gate_supply_disable_level_i(gate_supply_disable_level_i),
    .desat_detect_i(desat_detect_i),
    .protect_enable_i(protect_enable_i),
    .chip_select_n_i(chip_select_n_i),
    .serial_data_i(serial_data_i),
    .command_valid_i(command_valid_i),
    .command_byte_i(command_byte_i),
    .hs_gate_on_o(hs_gate_on_o),
    .hs_gate_off_o(hs_gate_off_o),
    .ls_gate_on_o(ls_gate_on_o),
    .ls_gate_off_o(ls_gate_off_o),
    .hold_off_o(hold_off_o),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o),
    .interrupt_o(interrupt_o),
    .phase_error_o(phase_error_o),
    .status_upper_o(status_upper_o),
    .interrupt_mask_upper_o(interrupt_mask_upper_o),
    .mode_o(mode_o)
  );
  host_model u_host_model
  (
    .clk_i(clk_i),
    .reset_pin_n_o(reset_pin_n_i),
    .en_first_o(enable_input_first_i),
    .en_second_o(enable_input_second_i),
    .ls_cmd_o(low_side_command_in_i),
    .hs_cmd_n_o(high_side_command_in_n_i),
    .cmd_valid_o(command_valid_i),
    .cmd_byte_o(command_byte_i)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait; a miss ends the run
  task automatic wait_mode(input mode_t m);
    int n;
    n = 0;
    while (mode_o !== m && n < 40)
    begin
      tick(1);
      n++;
    end
    check("mode", 8'(m), 8'(mode_o));
    if (mode_o !== m)
      tally_and_finish();
  endtask
  initial
  begin
    tick(10);
    reset_i <= 1'b0;
    tick(3);
    check("sleep", 8'(MODE_SLEEP), 8'(mode_o));
    check("mask", 8'h0F, 8'(interrupt_mask_upper_o));
    $display("test sleep done");
    u_host_model.set_pins(1'b1, 1'b0);
    wait_mode(MODE_STANDBY);
    chip_select_n_i <= 1'b0;
    serial_data_i <= 1'b1;
    tick(3);
    check("so", 8'h03, {6'h00, serial_out_oe_o, serial_out_o});
    chip_select_n_i <= 1'b1;
    $display("test standby done");
    u_host_model.init_run();
    wait_mode(MODE_ENABLE);
    u_host_model.set_gates(3'h0, 3'h6);
    tick(40);
    check("hs early", 8'h00, 8'(hs_gate_on_o));
    u_host_model.set_gates(3'h5, 3'h7);
    tick(40);
    check("ls on", 8'h05, 8'(ls_gate_on_o));
    phase_node_sense_i <= 3'h1;
    u_host_model.set_gates(3'h0, 3'h2);
    tick(10);
    check("deadtime", 8'h00, 8'(hs_gate_on_o));
    tick(80);
    check("hs on", 8'h05, 8'(hs_gate_on_o));
    check("hs err", 8'h01, 8'(phase_error_o));
    phase_node_sense_i <= 3'h2;
    u_host_model.set_gates(3'h2, 3'h7);
    tick(80);
    check("ls err", 8'h11, {3'h0, phase_error_o, status_upper_o});
    check("irq", 8'h01, 8'(interrupt_o));
    u_host_model.send_cmd(8'h30);
    check("masked", 8'h00, 8'(interrupt_o));
    check("mask zero", 8'h00, 8'(interrupt_mask_upper_o));
    u_host_model.send_cmd(8'h3F);
    u_host_model.send_cmd(8'h71);
    check("live", 8'h01, 8'(status_upper_o));
    u_host_model.set_gates(3'h0, 3'h7);
    tick(3);
    u_host_model.send_cmd(8'h71);
    check("clear", 8'h00, {3'h0, interrupt_o, status_upper_o});
    $display("test enable done");
    gate_drive_supply_low_i <= 1'b1;
    tick(150);
    gate_drive_supply_low_i <= 1'b0;
    tick(2);
    check("glitch", 8'(MODE_ENABLE), 8'(mode_o));
    gate_drive_supply_low_i <= 1'b1;
    tick(200);
    check("fault", 8'(MODE_FAULT), 8'(mode_o));
    check("strong", 8'h3F, {2'h0, hs_gate_off_o, ls_gate_off_o});
    tick(2000);
    check("weak off", 8'h00, {2'h0, hs_gate_off_o, ls_gate_off_o});
    check("weak hold", 8'h01, 8'(hold_off_o));
    u_host_model.set_gates(3'h4, 3'h7);
    gate_drive_supply_low_i <= 1'b0;
    wait_mode(MODE_INIT);
    tick(30);
    check("ls follow", 8'h04, 8'(ls_gate_on_o));
    check("float", 8'h00, 8'({hs_gate_on_o[2], hs_gate_off_o[2]}));
    check("float hold", 8'h00, 8'(hold_off_o));
    desat_detect_i <= 1'b1;
    protect_enable_i <= 1'b1;
    tick(2);
    check("desat", 8'(MODE_FAULT), 8'(mode_o));
    desat_detect_i <= 1'b0;
    protect_enable_i <= 1'b0;
    wait_mode(MODE_INIT);
    $display("test undervoltage done");
    u_host_model.set_gates(3'h0, 3'h7);
    u_host_model.set_pins(1'b1, 1'b0);
    wait_mode(MODE_STANDBY);
    gate_supply_disable_level_i <= 1'b1;
    tick(2);
    check("disable", 8'h01, 8'(hold_off_o));
    u_host_model.set_pins(1'b0, 1'b0);
    wait_mode(MODE_SLEEP);
    check("sleep clr", 8'h00, 8'(status_upper_o));
    $display("test shutdown done");
    tally_and_finish();
  end
endmodule
bind predriver_mode_fault_control predriver_mode_fault_control_assertions
  u_chk
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .reset_pin_n_i(reset_pin_n_i),
    .enable_input_first_i(enable_input_first_i),
    .gate_drive_supply_low_i(gate_drive_supply_low_i),
    .gate_supply_disable_level_i(gate_supply_disable_level_i),
    .chip_select_n_i(chip_select_n_i),
    .command_valid_i(command_valid_i),
    .hs_gate_on_o(hs_gate_on_o),
    .hold_off_o(hold_off_o),
    .serial_out_oe_o(serial_out_oe_o),
    .interrupt_o(interrupt_o),
    .phase_error_o(phase_error_o),
    .status_upper_o(status_upper_o),
    .interrupt_mask_upper_o(interrupt_mask_upper_o),
    .mode_o(mode_o)
  );
